/* opsf_cfg.svh */
// opsf_cfg.svh - offsets, reset values, field positions and timing counts
// assumes: included by the design module, 100 MHz clock
`ifndef OPSF_CFG_SVH
`define OPSF_CFG_SVH

// ****************************************************************
// register byte offsets on the AHB-Lite bus
// ****************************************************************
`define OPSF_OFS_PIN23      12'h000
`define OPSF_OFS_PIN24      12'h004
`define OPSF_OFS_PIN25      12'h008
`define OPSF_OFS_RSVD       12'h00C
`define OPSF_OFS_PIN49      12'h010
`define OPSF_OFS_FILT       12'h014
`define OPSF_OFS_MODE       12'h018
`define OPSF_OFS_STATUS     12'h01C

// ****************************************************************
// reset values
// ****************************************************************
`define OPSF_RST_PIN23      16'h000C
`define OPSF_RST_PIN24      16'h0004
`define OPSF_RST_PIN25      16'h0007
`define OPSF_RST_RSVD       16'h0003
`define OPSF_RST_PIN49      16'h0002
`define OPSF_RST_FILT       16'h0002
`define OPSF_RST_MODE       16'h0000

// ****************************************************************
// field positions
// ****************************************************************
`define OPSF_SEL_MSB        5
`define OPSF_FILT_MSB       1
`define OPSF_MODE_MSB       1
`define OPSF_ABS_EN_BIT     2
`define OPSF_ABS_ACT_BIT    3

// ****************************************************************
// filter windows in ns and cycles at 100 MHz (longest time, round down)
// ****************************************************************
`define OPSF_CLK_NS         10
`define OPSF_WIN1_NS        1777000
`define OPSF_WIN2_NS        3555000
`define OPSF_WIN3_NS        5333000
`define OPSF_WIN1_CYC       (`OPSF_WIN1_NS / `OPSF_CLK_NS)
`define OPSF_WIN2_CYC       (`OPSF_WIN2_NS / `OPSF_CLK_NS)
`define OPSF_WIN3_CYC       (`OPSF_WIN3_NS / `OPSF_CLK_NS)

`endif

/* opsf_pkg.sv */
// opsf_pkg.sv - types shared by the pin select and input filter block
// assumes: nothing beyond a SystemVerilog compiler
package opsf_pkg;

  // ****************************************************************
  // control modes
  // ****************************************************************
  typedef enum logic [1:0] {
    OPSF_MODE_POS = 2'h0,
    OPSF_MODE_SPD = 2'h1,
    OPSF_MODE_TRQ = 2'h3
  } opsf_mode_t;

  // ****************************************************************
  // bus slave state, Gray ordered
  // ****************************************************************
  typedef enum logic [1:0] {
    OPSF_BUS_IDLE  = 2'h0,
    OPSF_BUS_WRITE = 2'h1,
    OPSF_BUS_READ  = 2'h3
  } opsf_bus_t;

  // ****************************************************************
  // internal status signals that a selector can route to a pin
  // ****************************************************************
  typedef struct packed {
    logic ready;        // code 02
    logic alarm;        // code 03
    logic in_position;  // code 04 position mode
    logic speed_reached;// code 04 speed, 0A speed and torque
    logic brake;        // code 05
    logic dyn_brake;    // code 06
    logic torque_limit; // code 07 position and speed
    logic speed_limit;  // code 07 torque
    logic warning;      // code 08
    logic battery_warn; // code 09
    logic zero_speed;   // code 0C
  } opsf_status_t;

endpackage : opsf_pkg

/* opsf_top.sv */
// opsf_top.sv - output pin function select and input chatter filter
// assumes: one 100 MHz clock, AHB-Lite single word transfers, synchronous
// discrete inputs, status signals from the amplifier core
//
// Functional notes
// R1 - pin 24 selector picks its driving signal, resets to code 0004h.
// R2 - pin 25 selector picks its driving signal, resets to code 0007h.
// R3 - pin 49 selector picks its driving signal, resets to code 0002h.
// R4 - all selectors share the first pin's code table and mode validity.
// R5 - filter code 0 none; 1, 2, 3 give 1.777, 3.555, 5.333 ms.
// R6 - filter setting resets to 0002h and acts on external inputs.
// R7 - with transfer enabled, pin 23 carries transfer signal in transfer mode.
// R8 - software leaves the reserved setting at 0003h, never other values.
// R9 - a code without a signal in this mode is invalid, pin off.
// R10 - filtered input changes after a full stable window; code 0 passes.
`timescale 1ns/100ps
`default_nettype none
`include "opsf_cfg.svh"

module opsf_top #(
  parameter int NUM_IN   = 8,
  parameter int WIN1_CYC = `OPSF_WIN1_CYC,
  parameter int WIN2_CYC = `OPSF_WIN2_CYC,
  parameter int WIN3_CYC = `OPSF_WIN3_CYC
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [11:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // amplifier core status
  input  wire opsf_pkg::opsf_status_t status,
  input  wire logic                 abs_transfer_mode,
  input  wire logic                 abs_transfer_bit,
  // external discrete inputs
  input  wire logic [NUM_IN-1:0]    raw_in,
  output logic      [NUM_IN-1:0]    filt_in,
  // output pins
  output logic                      pin23_out,
  output logic                      pin24_out,
  output logic                      pin25_out,
  output logic                      pin49_out
);

  localparam int CW = 23;

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  // status register holds at most 12 filtered inputs
  if (NUM_IN < 1 || NUM_IN > 12 || WIN1_CYC < 1 || WIN2_CYC < WIN1_CYC ||
      WIN3_CYC < WIN2_CYC || WIN3_CYC >= (1 << CW)) begin : g_bad_param
    $error("opsf_top: unsupported parameter values");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    opsf_pkg::opsf_bus_t bus;
    logic [11:0]         addr;
    logic [15:0]         sel23;
    logic [15:0]         sel24;
    logic [15:0]         sel25;
    logic [15:0]         rsvd;
    logic [15:0]         sel49;
    logic [15:0]         filt;
    logic [15:0]         mode;
    logic [31:0]         rdata;
    logic [NUM_IN-1:0]   filt_in;
    logic [3:0]          pins;
  } opsf_state_t;

  opsf_state_t st;
  opsf_state_t next_st;

  // filter counters live beside the struct, one per input
  logic [CW-1:0] cnt      [NUM_IN];
  logic [CW-1:0] next_cnt [NUM_IN];

  // ****************************************************************
  // selector decode, shared code table for every pin
  // ****************************************************************
  function automatic logic opsf_decode(input logic [15:0] code,
                                       input logic [1:0] mode,
                                       input opsf_pkg::opsf_status_t s);
    logic v;
    v = 1'b0;
    case (code[`OPSF_SEL_MSB:0])                                  // R4
      6'h02: v = s.ready;
      6'h03: v = s.alarm;
      6'h04: v = (mode == opsf_pkg::OPSF_MODE_POS) ? s.in_position :
                 (mode == opsf_pkg::OPSF_MODE_SPD) ? s.speed_reached :
                 1'b0;
      6'h05: v = s.brake;
      6'h06: v = s.dyn_brake;
      6'h07: v = (mode == opsf_pkg::OPSF_MODE_TRQ) ? s.speed_limit :
                 s.torque_limit;
      6'h08: v = s.warning;
      6'h09: v = s.battery_warn;
      6'h0A: v = (mode == opsf_pkg::OPSF_MODE_POS) ? 1'b0 :
                 s.speed_reached;
      6'h0C: v = s.zero_speed;
      default: v = 1'b0;                                          // R9
    endcase
    if (code[15:`OPSF_SEL_MSB+1] != 10'h000)
      v = 1'b0;                                                   // R9
    return v;
  endfunction : opsf_decode

  // window length chosen by the filter setting
  function automatic logic [CW-1:0] opsf_window(input logic [1:0] c);
    logic [CW-1:0] w;
    w = '0;
    case (c)                                                      // R5
      2'h1: w = CW'(WIN1_CYC);
      2'h2: w = CW'(WIN2_CYC);
      2'h3: w = CW'(WIN3_CYC);
      default: w = '0;
    endcase
    return w;
  endfunction : opsf_window

  logic [CW-1:0] win;
  logic [1:0]    md;
  logic          abs_swap;

  assign win = opsf_window(st.filt[`OPSF_FILT_MSB:0]);
  assign md  = st.mode[`OPSF_MODE_MSB:0];
  assign abs_swap = st.mode[`OPSF_ABS_EN_BIT] && abs_transfer_mode;

  // ****************************************************************
  // chatter filter, one counter per input
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
      always_comb begin
        next_cnt[gi] = '0;
        if (win != '0 && raw_in[gi] != st.filt_in[gi]) begin
          next_cnt[gi] = cnt[gi] + CW'(1);                        // R10
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt[gi] <= '0;
        end else begin
          cnt[gi] <= next_cnt[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // next state: bus slave, registers, filter outputs, pin muxes
  // ****************************************************************
  always_comb begin
    logic [31:0] rd;
    next_st = st;
    rd      = 32'h0000_0000;
    // write data phase stores into the addressed register
    if (st.bus == opsf_pkg::OPSF_BUS_WRITE) begin
      if (st.addr == `OPSF_OFS_PIN23) begin
        next_st.sel23 = hwdata[15:0];
      end else if (st.addr == `OPSF_OFS_PIN24) begin
        next_st.sel24 = hwdata[15:0];                             // R1
      end else if (st.addr == `OPSF_OFS_PIN25) begin
        next_st.sel25 = hwdata[15:0];                             // R2
      end else if (st.addr == `OPSF_OFS_RSVD) begin
        next_st.rsvd = hwdata[15:0];                              // R8
      end else if (st.addr == `OPSF_OFS_PIN49) begin
        next_st.sel49 = hwdata[15:0];                             // R3
      end else if (st.addr == `OPSF_OFS_FILT) begin
        next_st.filt = hwdata[15:0];                              // R6
      end else if (st.addr == `OPSF_OFS_MODE) begin
        next_st.mode = {13'h0000, hwdata[2:0]};
      end
    end
    // address phase
    next_st.bus = opsf_pkg::OPSF_BUS_IDLE;
    if (hsel && hready && htrans[1]) begin
      next_st.addr = {haddr[11:2], 2'h0};
      next_st.bus  = hwrite ? opsf_pkg::OPSF_BUS_WRITE :
                              opsf_pkg::OPSF_BUS_READ;
      if (haddr[11:2] == 10'(`OPSF_OFS_PIN23 >> 2)) begin
        rd = {16'h0000, st.sel23};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_PIN24 >> 2)) begin
        rd = {16'h0000, st.sel24};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_PIN25 >> 2)) begin
        rd = {16'h0000, st.sel25};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_RSVD >> 2)) begin
        rd = {16'h0000, st.rsvd};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_PIN49 >> 2)) begin
        rd = {16'h0000, st.sel49};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_FILT >> 2)) begin
        rd = {16'h0000, st.filt};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_MODE >> 2)) begin
        rd = {16'h0000, st.mode};
      end else if (haddr[11:2] == 10'(`OPSF_OFS_STATUS >> 2)) begin
        rd = {16'h0000, 12'(st.filt_in), st.pins};
      end
      next_st.rdata = rd;                                         // unmapped reads 0
    end
    // filter outputs follow raw input after a full stable window
    for (int i = 0; i < NUM_IN; i++) begin
      if (win == '0) begin
        next_st.filt_in[i] = raw_in[i];                           // R10
      end else if (raw_in[i] != st.filt_in[i] && cnt[i] + CW'(1) >= win) begin
        next_st.filt_in[i] = raw_in[i];                           // R10
      end
    end
    // pin muxes
    next_st.pins[0] = abs_swap ? abs_transfer_bit :               // R7
                      opsf_decode(st.sel23, md, status);
    next_st.pins[1] = opsf_decode(st.sel24, md, status);          // R1
    next_st.pins[2] = opsf_decode(st.sel25, md, status);          // R2
    next_st.pins[3] = opsf_decode(st.sel49, md, status);          // R3
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.bus     <= opsf_pkg::OPSF_BUS_IDLE;
      st.addr    <= 12'h000;
      st.sel23   <= `OPSF_RST_PIN23;
      st.sel24   <= `OPSF_RST_PIN24;                              // R1
      st.sel25   <= `OPSF_RST_PIN25;                              // R2
      st.rsvd    <= `OPSF_RST_RSVD;
      st.sel49   <= `OPSF_RST_PIN49;                              // R3
      st.filt    <= `OPSF_RST_FILT;                               // R6
      st.mode    <= `OPSF_RST_MODE;
      st.rdata   <= 32'h0000_0000;
      st.filt_in <= '0;
      st.pins    <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;   // zero wait states
  assign hresp     = 1'b0;   // always okay
  assign filt_in   = st.filt_in;
  assign pin23_out = st.pins[0];
  assign pin24_out = st.pins[1];
  assign pin25_out = st.pins[2];
  assign pin49_out = st.pins[3];

endmodule : opsf_top

`default_nettype wire

/* opsf_properties.sv */
// opsf_properties.sv - concurrent checks on the opsf_top ports
// assumes: bound into opsf_top, one clock, zero-wait single word writes
`timescale 1ns/100ps
`default_nettype none
module opsf_chk #(
  parameter int NUM_IN   = 8,
  parameter int WIN1_CYC = 4,
  parameter int WIN2_CYC = 8
) (
  // clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // bus
  input wire logic                   hsel,
  input wire logic [11:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  // core side and pins
  input wire opsf_pkg::opsf_status_t status,
  input wire logic                   abs_transfer_mode,
  input wire logic                   abs_transfer_bit,
  input wire logic [NUM_IN-1:0]      raw_in,
  input wire logic [NUM_IN-1:0]      filt_in,
  input wire logic                   pin24_out,
  input wire logic                   pin25_out,
  input wire logic                   pin23_out,
  input wire logic                   pin49_out
);
  // ****************************************************************
  // shadow of the register file, snooped from bus writes
  // ****************************************************************
  logic [15:0]      shd [8];
  logic             wp;
  logic [2:0]       wa;
  wire logic [1:0]  fc = shd[5][1:0];
  wire logic [15:0] md = shd[6];

  // write data lands at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp  <= 1'b0;
      wa  <= 3'h0;
      shd <= '{16'h000C, 16'h0004, 16'h0007, 16'h0003,
               16'h0002, 16'h0002, 16'h0000, 16'h0000};
    end else begin
      wp <= hsel && hready && htrans[1] && hwrite && haddr[11:5] == 7'h0;
      wa <= haddr[4:2];
      if (wp) shd[wa] <= hwdata[15:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_BUS_READY: assert property (hreadyout)
    else $error("slave inserted a wait state");
  AST_BUS_OKAY: assert property (!hresp)
    else $error("slave gave an error response");
  AST_FILT_PASS: assert property (
    fc == 2'h0 |=> filt_in[0] == $past(raw_in[0]))
    else $error("unfiltered input did not pass through");
  AST_FILT_FOLLOW: assert property (
    $changed(filt_in[0]) |-> filt_in[0] == $past(raw_in[0]))
    else $error("filtered input took a level the raw input lacked");
  AST_FILT_WIN1: assert property (
    $changed(filt_in[0]) && fc == 2'h1 |->
      $past(raw_in[0], WIN1_CYC - 1) == filt_in[0])
    else $error("short window let a change through early");
  AST_FILT_WIN2: assert property (
    $changed(filt_in[0]) && fc == 2'h2 |->
      $past(raw_in[0], WIN2_CYC - 1) == filt_in[0])
    else $error("middle window let a change through early");
  AST_PIN24_POS: assert property (
    shd[1] == 16'h0004 && md[1:0] == 2'h0 |=>
      pin24_out == $past(status.in_position))
    else $error("pin 24 does not carry in-position");
  AST_PIN24_OFF: assert property (
    shd[1] == 16'h0004 && md[1:0] == 2'h3 |=> !pin24_out)
    else $error("pin 24 driven by a code invalid in this mode");
  AST_PIN25_TRQ: assert property (
    shd[2] == 16'h0007 && md[1:0] == 2'h3 |=>
      pin25_out == $past(status.speed_limit))
    else $error("pin 25 does not carry the speed limit");
  AST_PIN49_RDY: assert property (
    shd[4] == 16'h0002 |=> pin49_out == $past(status.ready))
    else $error("pin 49 does not carry ready");
  AST_PIN_SHARED: assert property (
    shd[1] == shd[4] |=> pin24_out == pin49_out)
    else $error("same code decodes differently on two pins");
  AST_PIN23_ABS: assert property (
    md[2] && abs_transfer_mode |=> pin23_out == $past(abs_transfer_bit))
    else $error("pin 23 does not carry the transfer bit");
endmodule : opsf_chk

bind opsf_top opsf_chk #(
  .NUM_IN(NUM_IN), .WIN1_CYC(WIN1_CYC), .WIN2_CYC(WIN2_CYC)
) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .status(status),
  .abs_transfer_mode(abs_transfer_mode),
  .abs_transfer_bit(abs_transfer_bit), .raw_in(raw_in),
  .filt_in(filt_in), .pin24_out(pin24_out), .pin25_out(pin25_out),
  .pin23_out(pin23_out), .pin49_out(pin49_out)
);
`default_nettype wire

/* opsf_host_model.sv */
// opsf_host_model.sv - host controller driving the discrete inputs
// assumes: lvl set by the bench; bounce gives the chatter length in cycles
`timescale 1ns/100ps
`default_nettype none
module opsf_host_model #(
  parameter int N = 8
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // commanded level and chatter
  input  wire logic [N-1:0] lvl,
  input  wire logic [3:0]   bounce,
  // contact levels
  output logic      [N-1:0] raw_in
);
  logic [N-1:0] last;
  logic [3:0]   cnt;

  // a new level chatters for bounce cycles before it settles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last   <= '0;
      cnt    <= 4'h0;
      raw_in <= '0;
    end else begin
      last   <= lvl;
      cnt    <= (lvl != last) ? bounce : (cnt != 4'h0) ? cnt - 4'h1 : cnt;
      raw_in <= cnt[0] ? ~lvl : lvl;  // odd counts bounce back
    end
  end
endmodule : opsf_host_model
`default_nettype wire

/* tb.sv */
// tb.sv - self-checking bench for opsf_top
// assumes: short filter windows 4/8/12 cycles, zero-wait bus slave
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int W1 = 4, W2 = 8, W3 = 12;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0, m;
  logic [31:0] hwdata = '0, rd, hrdata;
  logic hreadyout, hresp, p23, p24, p25, p49, pr = 1'b0, pf = 1'b0;
  logic abs_m = 1'b0, abs_b = 1'b0;
  opsf_pkg::opsf_status_t status = '0;
  logic [7:0] lvl = '0, raw_in, filt_in;
  logic [3:0] bounce = '0;
  int bad_count = 0, n_checks = 0, cyc = 0, run = 0, lat = 0, nchg = 0, e;
  int idx [16] = '{-1, -1, 10, 9, 8, 6, 5, 4, 2, 1, 7, -1, 0, -1, -1, -1};
  int win [4] = '{0, W1, W2, W3};
  logic [15:0] rv [7] = '{16'h000C, 16'h0004, 16'h0007, 16'h0003,
                          16'h0002, 16'h0002, 16'h0000};
  logic [15:0] codes [13] = '{16'h0, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6,
                              16'h7, 16'h8, 16'h9, 16'hA, 16'hC, 16'hF, 16'h44};

  opsf_top #(.NUM_IN(8), .WIN1_CYC(W1), .WIN2_CYC(W2), .WIN3_CYC(W3)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .status(status), .abs_transfer_mode(abs_m),
    .abs_transfer_bit(abs_b), .raw_in(raw_in), .filt_in(filt_in),
    .pin23_out(p23), .pin24_out(p24), .pin25_out(p25), .pin49_out(p49));
  opsf_host_model #(.N(8)) u_host (.hclk(hclk), .hresetn(hresetn),
    .lvl(lvl), .bounce(bounce), .raw_in(raw_in));

  // ****************************************************************
  // clock, timeout and filter latency monitor
  // ****************************************************************
  initial forever #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      test_done;
    end
    if (filt_in[0] !== pf) begin
      lat = run;
      nchg++;
    end
    run = (raw_in[0] !== pr) ? 0 : run + 1;
    pr = raw_in[0];
    pf = filt_in[0];
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // one single-word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [11:0] a, input int d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // flip every input, optionally with chatter, and time the filter
  task automatic tog(input logic [3:0] b, input int w);
    int n0;
    int k;
    n0 = nchg;
    k = 0;
    lvl <= ~lvl;
    bounce <= b;
    while (nchg == n0 && k < 80) begin
      @(posedge hclk);
      k++;
    end
    chk(32'(nchg - n0), 32'd1);
    chk(32'(lat >= (w > 0 ? w - 1 : 0) && lat <= w), 32'd1);
    bus(1'b0, 12'h01C, 0);
    chk(32'(rd[11:4]), 32'(lvl));
  endtask : tog

  // a pulse one cycle shorter than the window must be swallowed
  task automatic glitch(input int w);
    int n0;
    n0 = nchg;
    lvl <= ~lvl;
    repeat (w - 1) @(posedge hclk);
    lvl <= ~lvl;
    repeat (w + 4) @(posedge hclk);
    chk(32'(nchg - n0), 32'd0);
  endtask : glitch

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 12'(4 * i), 0);
      chk(rd, {16'h0, rv[i]});
    end
    bus(1'b1, 12'h020, 32'hFFFF);
    bus(1'b0, 12'h020, 0);
    chk(rd, 32'h0);
    tog(4'h0, W2);
    glitch(W2);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 12'h014, c);
      tog(4'h0, win[c]);
      if (c > 0) begin
        tog(4'h5, win[c]);
        glitch(win[c]);
      end
    end
    for (int mi = 0; mi < 4; mi++) begin
      m = 2'(mi);
      bus(1'b1, 12'h018, 32'(m));
      foreach (codes[k]) begin
        for (int a = 0; a < 4; a++) bus(1'b1, 12'(a == 3 ? 16 : 4 * a), codes[k]);
        e = (codes[k][15:4] != 12'h0) ? -1 : idx[codes[k][3:0]];
        if (codes[k] == 16'h4 && m != 2'h0) e = (m == 2'h1) ? 7 : -1;
        if (codes[k] == 16'h7 && m == 2'h3) e = 3;
        if (codes[k] == 16'hA && m == 2'h0) e = -1;
        for (int b = 0; b < 11; b++) begin
          status <= opsf_pkg::opsf_status_t'(11'h1 << b);
          repeat (2) @(posedge hclk);
          chk(32'({p23, p24, p25, p49}), (e == b) ? 32'hF : 32'h0);
        end
      end
    end
    status <= '0;
    bus(1'b1, 12'h000, 32'h000C);
    abs_b <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 12'h018, {29'h0, k[1], 2'h0});
      abs_m <= k[0];
      repeat (2) @(posedge hclk);
      chk(32'(p23), 32'(k == 3));
    end
    abs_b <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'(p23), 32'h0);
    test_done;
  end
endmodule : tb
`default_nettype wire
